// ---- logic/pmcs_sequencer.sv ----
// How it works
// - continuous mode repeats shunt then bus conversions
// - current follows shunt; power uses that current
// - accumulate samples until averaging count reached
// - outputs loaded only when averaging completes
// - outputs hold until next completed set
// - data register reads never disturb conversion
// - modes for shunt-only or bus-only conversion
// - triggered mode write starts one set
// - registers stay accessible while powered down
// - wait recovery interval after leaving power-down
// - stay powered down until active mode written
// - ready flag set after whole set finishes
// - configuration write clears ready, except power-down
// - mask register read clears ready flag
// - bus register keeps fixed weight per code
`timescale 1ns/1ps
`default_nettype none
module pmcs_sequencer
    import pmcs_pkg::*;
(
    // clock, reset, enable
    input  wire logic         mclk,
    input  wire logic         arst_n,
    input  wire logic         ce,
    // register port from the serial engine
    input  wire pmcs_regreq_s req,
    output logic [15:0]       reg_rdata,
    // converter handshake
    output logic              adc_start,
    output logic              adc_chan,
    input  wire logic         adc_done,
    input  wire logic [15:0]  adc_data,
    // status
    output logic              power_down,
    output logic              conv_ready
);

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rst_s1;
    logic rst_n;

    // two stages so release never lands near an edge
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rst_s1 <= 1'b0;
            rst_n  <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n  <= rst_s1;
        end
    end

    // ------------------------------------------------------------
    // state and storage
    // ------------------------------------------------------------
    pmcs_state_e              state;
    pmcs_state_e              next_state;
    logic [15:0]              config_q;
    logic [15:0]              mask_q;
    logic [10:0]              wake_cnt;
    logic [6:0]               sample_cnt;
    logic signed [15:0]       shunt_val;
    logic signed [15:0]       cur_val;
    logic [15:0]              bus_val;
    logic [15:0]              pw_val;
    logic signed [ACC_W-1:0]  acc_cur;
    logic [ACC_W-1:0]         acc_bus;
    logic [ACC_W-1:0]         acc_pw;
    logic [15:0]              out_cur;
    logic [15:0]              out_bus;
    logic [15:0]              out_pw;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire logic       cfg_wr    = ce & req.wr & (req.addr == OFS_CONFIG);
    wire logic       mask_wr   = ce & req.wr & (req.addr == OFS_MASK);
    wire logic       mask_rd   = ce & req.rd & (req.addr == OFS_MASK);
    wire logic [2:0] mode      = config_q[MODE_LSB +: 3];
    wire logic [2:0] new_mode  = req.wdata[MODE_LSB +: 3];
    wire logic [2:0] avg_sh    = config_q[AVG_LSB +: 3];
    wire logic [6:0] last_smp  = 7'((8'h01 << avg_sh) - 8'h01);
    wire logic       new_act   = pmcs_mode_active(new_mode);
    wire logic       set_rdy   = ce & (state == S_LOAD);
    wire logic       clr_rdy   = (cfg_wr & new_act) | mask_rd;
    wire logic [15:0] cur_mag  = cur_val[15] ? 16'(-cur_val) : cur_val;
    wire logic [31:0] pw_prod  = cur_mag * bus_val;

    // ------------------------------------------------------------
    // sequencer next state
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        if (cfg_wr) begin
            if (!new_act)
                next_state = S_OFF;
            else if (state == S_OFF || state == S_WAKE)
                next_state = S_WAKE;
            else
                next_state = S_START;
        end else begin
            case (state)
                S_OFF:      next_state = S_OFF;
                S_WAKE:     if (wake_cnt == WAKE_LAST) next_state = S_START;
                S_IDLE:     next_state = S_IDLE;
                S_START:    next_state = mode[0] ? S_SH_REQ : S_BUS_REQ;
                S_SH_REQ:   next_state = S_SH_WAIT;
                S_SH_WAIT:  if (adc_done) next_state = S_CURR;
                S_CURR:     next_state = mode[1] ? S_BUS_REQ : S_POWER;
                S_BUS_REQ:  next_state = S_BUS_WAIT;
                S_BUS_WAIT: if (adc_done) next_state = S_POWER;
                S_POWER:    next_state = S_ACCUM;
                S_ACCUM: begin
                    if (sample_cnt == last_smp)
                        next_state = S_LOAD;
                    else
                        next_state = mode[0] ? S_SH_REQ : S_BUS_REQ;
                end
                S_LOAD:     next_state = mode[2] ? S_START : S_IDLE;
                default:    next_state = S_OFF;
            endcase
        end
    end

    // converter request lines; data reads have no path in here
    assign adc_start  = (state == S_SH_REQ) | (state == S_BUS_REQ);
    assign adc_chan   = (state == S_BUS_REQ);

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    // state, wake timer and sample count
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state      <= S_WAKE;
            wake_cnt   <= 11'h000;
            sample_cnt <= 7'h00;
        end else if (ce) begin
            state      <= next_state;
            wake_cnt   <= (state == S_WAKE && next_state == S_WAKE && !cfg_wr)
                          ? wake_cnt + 11'h001 : 11'h000;
            if (state == S_START)
                sample_cnt <= 7'h00;
            else if (state == S_ACCUM)
                sample_cnt <= sample_cnt + 7'h01;
        end
    end

    // host registers, served in every state including power-down
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            config_q <= CONFIG_RST;
            mask_q   <= MASK_RST;
        end else begin
            if (cfg_wr)
                config_q <= req.wdata;
            if (mask_wr)
                mask_q   <= req.wdata & MASK_RW;
        end
    end

    // ready flag: a set in the same cycle as a clear wins
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            conv_ready <= 1'b0;
        else
            conv_ready <= set_rdy | (conv_ready & ~clr_rdy);
    end

    // powered-down indication for the analog front end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            power_down <= 1'b0;
        else if (ce)
            power_down <= (next_state == S_OFF);
    end

    // read data sampled before any clear takes effect
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 16'h0000;
        end else if (ce && req.rd) begin
            case (req.addr)
                OFS_CONFIG:  reg_rdata <= config_q;
                OFS_CURRENT: reg_rdata <= out_cur;
                OFS_BUS:     reg_rdata <= out_bus;
                OFS_POWER:   reg_rdata <= out_pw;
                OFS_MASK:    reg_rdata <= {mask_q[15:RDY_BIT+1], conv_ready, mask_q[RDY_BIT-1:0]};
                default:     reg_rdata <= 16'h0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // measurement datapath
    // ------------------------------------------------------------
    // samples; current taken from the shunt code at one code per lsb
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            shunt_val <= 16'sh0000;
            cur_val   <= 16'sh0000;
            bus_val   <= 16'h0000;
            pw_val    <= 16'h0000;
        end else if (ce) begin
            if (state == S_SH_WAIT && adc_done)
                shunt_val <= adc_data;
            if (state == S_CURR)
                cur_val   <= shunt_val;
            if (state == S_BUS_WAIT && adc_done)
                bus_val   <= adc_data;
            if (state == S_POWER)
                pw_val    <= pw_prod[POWER_SHIFT +: 16];
        end
    end

    // accumulators, cleared at every set start (also a restart)
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            acc_cur <= '0;
            acc_bus <= '0;
            acc_pw  <= '0;
        end else if (ce) begin
            if (state == S_START) begin
                acc_cur <= '0;
                acc_bus <= '0;
                acc_pw  <= '0;
            end else if (state == S_ACCUM) begin
                acc_cur <= acc_cur + ACC_W'(cur_val);
                acc_bus <= acc_bus + ACC_W'(bus_val);
                acc_pw  <= acc_pw + ACC_W'(pw_val);
            end
        end
    end

    // output registers move only at the end of a full set
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            out_cur <= 16'h0000;
            out_bus <= 16'h0000;
            out_pw  <= 16'h0000;
        end else if (ce && state == S_LOAD) begin
            if (mode[0])
                out_cur <= 16'(acc_cur >>> avg_sh);
            if (mode[1])
                out_bus <= 16'(acc_bus >> avg_sh);
            out_pw  <= 16'(acc_pw >> avg_sh);
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n || !ce);

    AST_CONT_REPEAT: assert property (
        state == S_LOAD && mode[2] && !cfg_wr |=> state == S_START)
        else $error("continuous mode did not restart");
    AST_CURR_THEN_POWER: assert property (
        state == S_SH_WAIT && adc_done && !cfg_wr |=> state == S_CURR
        ##1 (state == S_POWER || state == S_BUS_REQ || state == S_START || state == S_OFF))
        else $error("current not computed after shunt");
    AST_AVG_COUNT: assert property (
        state == S_ACCUM && !cfg_wr |=> sample_cnt == $past(sample_cnt) + 7'h01)
        else $error("sample count did not advance");
    AST_OUT_HOLD: assert property (
        $changed(out_bus) || $changed(out_pw) |-> $past(state) == S_LOAD)
        else $error("output register changed outside load");
    AST_READ_NO_DISTURB: assert property (
        req.rd && !req.wr && state == S_SH_WAIT && !adc_done |=> state == S_SH_WAIT)
        else $error("read disturbed a conversion");
    AST_BUS_ONLY: assert property (
        state == S_START && !mode[0] && !cfg_wr |=> state == S_BUS_REQ)
        else $error("bus-only mode started shunt");
    AST_SHOT_IDLE: assert property (
        state == S_LOAD && !mode[2] && !cfg_wr |=> state == S_IDLE
        ##1 (state == S_IDLE || $past(cfg_wr)))
        else $error("single shot did not stop");
    AST_PD_REG_ACCESS: assert property (
        state == S_OFF && mask_wr |=> mask_q == ($past(req.wdata) & MASK_RW))
        else $error("register write lost in power-down");
    AST_WAKE_TIME: assert property (
        state == S_START && $past(state) == S_WAKE |-> $past(wake_cnt) == WAKE_LAST)
        else $error("recovery interval cut short");
    AST_PD_STAY: assert property (
        state == S_OFF && !cfg_wr |=> state == S_OFF && power_down)
        else $error("left power-down without write");
    AST_RDY_CAUSE: assert property (
        $rose(conv_ready) |-> $past(state) == S_LOAD)
        else $error("ready set before set finished");
    AST_RDY_CLR_CFG: assert property (
        cfg_wr && new_act && state != S_LOAD |=> !conv_ready)
        else $error("configuration write kept ready");
    AST_RDY_CLR_MASK: assert property (
        mask_rd && state != S_LOAD |=> !conv_ready)
        else $error("mask read kept ready");
    AST_BUS_WEIGHT: assert property (
        state == S_LOAD && mode[1] && avg_sh == 3'h0 |=> out_bus == $past(bus_val))
        else $error("bus code rescaled");
    AST_RESTART: assert property (
        cfg_wr && new_act && state != S_OFF && state != S_WAKE |=> state == S_START)
        else $error("configuration write did not restart");

    COV_CONT_SET: cover property (state == S_LOAD && mode == 3'b111);
    COV_SHOT_DONE: cover property (state == S_LOAD ##1 state == S_IDLE);
    COV_WAKE_DONE: cover property (state == S_WAKE ##1 state == S_START);
    COV_RESTART: cover property (state == S_BUS_WAIT && cfg_wr && new_act);

endmodule : pmcs_sequencer
`default_nettype wire

// ---- logic/pmcs_pkg.sv ----
package pmcs_pkg;

    // ------------------------------------------------------------
    // register map and field layout
    // ------------------------------------------------------------
    localparam logic [7:0]  OFS_CONFIG  = 8'h00;
    localparam logic [7:0]  OFS_CURRENT = 8'h01;
    localparam logic [7:0]  OFS_BUS     = 8'h02;
    localparam logic [7:0]  OFS_POWER   = 8'h03;
    localparam logic [7:0]  OFS_MASK    = 8'h06;
    localparam logic [15:0] CONFIG_RST  = 16'h0007;   // continuous, both channels, 1 sample
    localparam logic [15:0] MASK_RST    = 16'h0000;
    localparam logic [15:0] MASK_RW     = 16'hfc03;   // ready flag and bits 2,4..9 not writable
    localparam int          MODE_LSB    = 0;
    localparam int          AVG_LSB     = 9;
    localparam int          RDY_BIT     = 3;

    // ------------------------------------------------------------
    // timing and datapath constants
    // ------------------------------------------------------------
    localparam int          WAKE_US     = 40;         // power-down recovery, microseconds
    localparam int          CLK_MHZ     = 40;
    localparam int          WAKE_CYC    = WAKE_US * CLK_MHZ;
    localparam logic [10:0] WAKE_LAST   = 11'(WAKE_CYC - 1);
    localparam int          POWER_SHIFT = 10;
    localparam int          ACC_W       = 23;         // 16 bits plus up to 128 samples

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        S_OFF, S_WAKE, S_IDLE, S_START, S_SH_REQ, S_SH_WAIT, S_CURR,
        S_BUS_REQ, S_BUS_WAIT, S_POWER, S_ACCUM, S_LOAD
    } pmcs_state_e;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } pmcs_regreq_s;

    // mode bits: [2] continuous, [1] bus channel, [0] shunt channel
    function automatic logic pmcs_mode_active(input logic [2:0] mode);
        return mode[1:0] != 2'b00;
    endfunction : pmcs_mode_active

endpackage : pmcs_pkg

// ---- dv/pmcs_adc_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// converter stand-in
// ------------------------------------------------------------
module pmcs_adc_model (
    // clock
    input  wire logic        mclk,
    // request from the sequencer
    input  wire logic        adc_start,
    input  wire logic        adc_chan,
    // code and latency picked by the bench
    input  wire logic [15:0] code_in,
    input  wire logic [7:0]  lat,
    // answer
    output logic             adc_done,
    output logic [15:0]      adc_data
);
    logic [7:0]  cnt;
    logic        busy;
    logic [15:0] val;

    initial begin
        adc_done = 1'b0;
        adc_data = 16'h0000;
        busy     = 1'b0;
        cnt      = 8'h00;
    end

    // a new start replaces a pending one; data toggles whenever not valid
    always @(posedge mclk) begin
        adc_done <= 1'b0;
        adc_data <= ~adc_data;
        if (adc_start) begin
            busy <= 1'b1;
            cnt  <= lat;
            val  <= adc_chan ? code_in : {1'b0, code_in[14:0]};  // shunt kept positive
        end else if (busy && cnt == 8'h00) begin
            busy     <= 1'b0;
            adc_done <= 1'b1;
            adc_data <= val;
        end else begin
            cnt <= cnt - 8'h01;
        end
    end
endmodule : pmcs_adc_model
`default_nettype wire

// ---- dv/power_monitor_conversion_sequencer_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module power_monitor_conversion_sequencer_tb;
    import pmcs_pkg::*;
    logic         mclk = 1'b0, arst_n = 1'b0, ce = 1'b1, rdy_q = 1'b0;
    pmcs_regreq_s req = '0;
    logic [15:0]  reg_rdata, adc_data, rd_v, e_cur, e_bus, e_pow;
    logic [15:0]  code_in = 16'h0000;
    logic         adc_start, adc_chan, adc_done, power_down, conv_ready;
    logic [7:0]   lat = 8'h06;
    logic [31:0]  seed = 32'hd7bd;
    logic [2:0]   mode = 3'b111, avg = 3'b000;
    logic         pch = 1'b0, skip = 1'b0;
    int           err_total = 0, total_checks = 0, cyc = 0, snap_n = 0;
    int           sh_n = 0, bs_n = 0, n_smp = 0, sh = 0, bs = 0;
    longint       s_cur = 0, s_bus = 0, s_pow = 0;

    pmcs_sequencer pmcs_sequencer_i (.mclk(mclk), .arst_n(arst_n), .ce(ce), .req(req),
        .reg_rdata(reg_rdata), .adc_start(adc_start), .adc_chan(adc_chan),
        .adc_done(adc_done), .adc_data(adc_data), .power_down(power_down),
        .conv_ready(conv_ready));
    pmcs_adc_model pmcs_adc_model_i (.mclk(mclk), .adc_start(adc_start), .adc_chan(adc_chan),
        .code_in(code_in), .lat(lat), .adc_done(adc_done), .adc_data(adc_data));

    always #12.5 mclk = ~mclk;

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs

    // random codes and latencies; cycle count doubles as hang guard
    always @(posedge mclk) begin
        seed    <= xs(seed);
        code_in <= seed[15:0];
        lat     <= 8'(seed[20:16]) + 8'h06;
        cyc     <= cyc + 1;
        if (cyc == 30000) begin
            err_total++;
            stop_test();
        end
    end

    // reference model; dones right after a restart belong to the old set
    always @(posedge mclk) begin
        if (conv_ready && !rdy_q) snap_n = sh_n + bs_n;
        rdy_q = conv_ready;
        if (req.wr && req.addr == OFS_CONFIG) begin
            mode = req.wdata[2:0];
            avg = req.wdata[11:9];
            s_cur = 0; s_bus = 0; s_pow = 0; n_smp = 0; skip = 1'b1;
        end else if (adc_done && !skip) begin
            if (pch) bs = int'(adc_data); else sh = int'(adc_data);
            if (pch || !mode[1]) begin
                s_cur += sh;
                s_bus += bs;
                s_pow += ((longint'(sh) * bs) >> 10) & 16'hffff;
                n_smp++;
                if (n_smp == (1 << avg)) begin
                    e_cur = 16'(s_cur >> avg);
                    e_bus = 16'(s_bus >> avg);
                    e_pow = 16'(s_pow >> avg);
                    s_cur = 0; s_bus = 0; s_pow = 0; n_smp = 0;
                end
            end
        end
        if (adc_start) begin
            pch = adc_chan;
            skip = 1'b0;
            if (adc_chan) bs_n++; else sh_n++;
        end
    end

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : stop_test

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk) req <= '{1'b1, 1'b0, a, d};
        @(posedge mclk) req <= '0;
        #1;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge mclk) req <= '{1'b0, 1'b1, a, 16'h0000};
        @(posedge mclk) req <= '0;
        #1 rd_v = reg_rdata;
    endtask : rd

    // polls with data reads, which must leave the set undisturbed
    task automatic wait_ready();
        for (int k = 0; k < 1500 && conv_ready !== 1'b1; k++) rd(OFS_CURRENT + 8'(k % 3));
        // one more edge so the model's flag-rise snapshot has been taken
        @(posedge mclk) #1;
        check("ready", 32'(conv_ready), 32'd1);
    endtask : wait_ready

    task automatic check_set(input string nm);
        rd(OFS_CURRENT);
        if (mode[0]) check("current", 32'(rd_v), 32'(e_cur));
        rd(OFS_BUS);
        if (mode[1]) check("bus", 32'(rd_v), 32'(e_bus));
        rd(OFS_POWER);
        if (mode[1:0] == 2'b11) check("power", 32'(rd_v), 32'(e_pow));
        $display("test %s done, mismatches %0d", nm, err_total);
    endtask : check_set

    task automatic wait_start(input int n, input int t0);
        int k;
        k = sh_n + bs_n + n;
        for (int i = 0; i < 3000 && sh_n + bs_n < k; i++) @(posedge mclk);
        #1;
        if (t0 > 0)
            check("wake", 32'(cyc - t0 >= WAKE_CYC && cyc - t0 <= WAKE_CYC + 8), 1);
    endtask : wait_start

    initial begin
        int b, t0;
        repeat (5) @(posedge mclk);
        check("rst_ready", 32'(conv_ready), 32'd0);
        arst_n <= 1'b1;
        #1 t0 = cyc;
        repeat (2) @(posedge mclk);
        rd(OFS_CONFIG);
        check("cfg_rst", 32'(rd_v), 32'(CONFIG_RST));
        rd(OFS_MASK);
        check("mask_rst", 32'(rd_v), 32'(MASK_RST));
        rd(8'h05);
        check("unmapped", 32'(rd_v), 32'd0);
        wait_start(1, t0);
        wait_ready();
        check_set("continuous");
        // averaging over four samples
        wr(OFS_CONFIG, 16'h0407);
        check("clr", 32'(conv_ready), 32'd0);
        b = sh_n + bs_n;
        wait_ready();
        check("samples", 32'(snap_n - b), 32'd8);
        check_set("average");
        rd(OFS_MASK);
        check("mask_flag", 32'(rd_v[RDY_BIT]), 32'd1);
        check("mask_clr", 32'(conv_ready), 32'd0);
        // restart in the middle of a set
        wait_start(3, 0);
        wr(OFS_CONFIG, 16'h0407);
        b = sh_n + bs_n;
        wait_ready();
        check("restart", 32'(snap_n - b), 32'd8);
        check_set("restart");
        // continuous single-channel codes, shunt only then bus only
        for (int m = 5; m < 7; m++) begin
            wr(OFS_CONFIG, 16'(m));
            wait_ready();
            check_set("cont_single");
        end
        // each triggered code twice, the rewrite alone re-arms it
        for (int m = 1; m < 4; m++) begin
            repeat (2) begin
                wr(OFS_CONFIG, 16'(m));
                b = sh_n;
                t0 = bs_n;
                wait_ready();
                check_set("single");
                repeat (150) @(posedge mclk);
                check("shunt_n", 32'(sh_n - b), 32'(m & 1));
                check("bus_n", 32'(bs_n - t0), 32'(m >> 1));
            end
        end
        // power-down keeps registers alive and the flag standing
        wr(OFS_CONFIG, 16'h0000);
        check("keep_rdy", 32'(conv_ready), 32'd1);
        check("pdown", 32'(power_down), 32'd1);
        wr(OFS_MASK, 16'hffff);
        rd(OFS_MASK);
        check("mask_rw", 32'(rd_v), 32'(MASK_RW | 16'h0008));
        // a write while the clock enable is low must be frozen out
        @(posedge mclk) ce <= 1'b0;
        wr(OFS_MASK, 16'h0000);
        @(posedge mclk) ce <= 1'b1;
        rd(OFS_MASK);
        check("ce_hold", 32'(rd_v), 32'(MASK_RW));
        b = sh_n + bs_n;
        repeat (100) @(posedge mclk);
        check("asleep", 32'(sh_n + bs_n - b), 32'd0);
        rd(OFS_BUS);
        check("hold", 32'(rd_v), 32'(e_bus));
        wr(OFS_CONFIG, 16'h0003);
        t0 = cyc;
        check("awake", 32'(power_down), 32'd0);
        wait_start(1, t0);
        wait_ready();
        check_set("wake");
        wr(OFS_CURRENT, 16'hffff);
        rd(OFS_CURRENT);
        check("ro", 32'(rd_v), 32'(e_cur));
        stop_test();
    end
endmodule : power_monitor_conversion_sequencer_tb
`default_nettype wire
